// ==== inc/prc_consts.svh ====
// constants shared by both ends of the pulse run-to-limit command link
// assumes a single 200 MHz clock; included by bare name
//
// Notes on behaviour
// - request rise loads run-to-limit on chosen output
// - read-error rise returns current error code
// - stored code holds until next command
// - codes 0 and 100 to 103 meaning
// - codes 104 to 108 meaning
// - codes 109 to 112 meaning
// - unreachable module reports code 2001
// - limit byte: low digit input, high edge
// - host configures input as limit first
// - finish raises exactly one of success, error
// - duty 0 to 99, zero means fifty
// - host picks output 0-3, module 0-255
// - rate 20 Hz to 25k or 250k
// - pulses run until selected limit event
// - host sets direction, then enables output; the bench sets both in one OUTCTL write
// - host reads error code right after failure
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

`define PRC_ERR_NONE      16'h0000
`define PRC_ERR_CMD       16'h0064
`define PRC_ERR_FILE      16'h0065
`define PRC_ERR_FTYPE     16'h0066
`define PRC_ERR_PROFILE   16'h0067
`define PRC_ERR_NOT_LIMIT 16'h0068
`define PRC_ERR_EDGE      16'h0069
`define PRC_ERR_IN_FUNC   16'h006A
`define PRC_ERR_IN_NUM    16'h006B
`define PRC_ERR_PRESET    16'h006C
`define PRC_ERR_TBL_FULL  16'h006D
`define PRC_ERR_TBL_IDX   16'h006E
`define PRC_ERR_REG_NUM   16'h006F
`define PRC_ERR_REG_CFG   16'h0070
`define PRC_ERR_NO_LINK   16'h07D1

`define PRC_LIM_IN        3:0
`define PRC_LIM_EDGE      7:4
`define PRC_EDGE_RISE     4'h0
`define PRC_EDGE_FALL     4'h1
`define PRC_EDGE_BOTH     4'h2
`define PRC_IN_MAX        4'h3

`define PRC_CLK_HZ        28'hBEBC200
`define PRC_DUTY_STEP     28'h01E8480
`define PRC_DUTY_MAX      8'h63
`define PRC_DUTY_HALF     8'h32
`define PRC_FREQ_MIN      18'h00014
`define PRC_FREQ_MAX_BASE 18'h061A8
`define PRC_FREQ_MAX_ENH  18'h3D090
`define PRC_CLK_PERIOD_NS 5
`define PRC_LOAD_TIME_NS  40
`define PRC_LOAD_CYC ((`PRC_LOAD_TIME_NS+`PRC_CLK_PERIOD_NS-1)/`PRC_CLK_PERIOD_NS)

`define PRC_REG_CTRL      8'h00
`define PRC_REG_FREQ      8'h04
`define PRC_REG_PARAM     8'h08
`define PRC_REG_OUTCTL    8'h0C
`define PRC_REG_STATUS    8'h10
`define PRC_REG_CODE      8'h14
`define PRC_REG_INT_STAT  8'h18
`define PRC_REG_INT_MASK  8'h1C
`define PRC_CTRL_RUN      0
`define PRC_CTRL_RDE      1
`define PRC_CTRL_OUT      5:4
`define PRC_PAR_LIM       7:0
`define PRC_PAR_DUTY      15:8
`define PRC_PAR_MOD       23:16
`define PRC_OC_EN         3:0
`define PRC_OC_DIR        7:4
`define PRC_INT_OK        0
`define PRC_INT_ERR       1
`define PRC_INT_CODE      2

`endif

// ==== inc/prc_pkg.sv ====
// types used by the pulse run-to-limit module end
// no dependencies
package prc_pkg;
	typedef enum logic [3:0] {
		PRC_IDLE  = 4'h1,
		PRC_CHECK = 4'h2,
		PRC_LOAD  = 4'h4,
		PRC_RDERR = 4'h8
	} prc_dev_state_t;
endpackage

// ==== inc/prc_link_if.sv ====
// command link between host controller and pulse output module
// both ends run on the same pclk
`timescale 1ns/100ps
interface prc_link_if;
	logic        run_to_limit_command;
	logic        read_error_command;
	logic [7:0]  mod_id;
	logic [1:0]  out_sel;
	logic [17:0] freq_hz;
	logic [7:0]  limit_sel;
	logic [7:0]  duty;
	logic [3:0]  out_en;
	logic [3:0]  dir;
	logic [3:0]  done_ok;
	logic [3:0]  done_err;
	logic [15:0] code;
	logic        code_valid;

	modport dev (
		input  run_to_limit_command, read_error_command, mod_id, out_sel,
		input  freq_hz, limit_sel, duty, out_en, dir,
		output done_ok, done_err, code, code_valid
	);
	modport host (
		output run_to_limit_command, read_error_command, mod_id, out_sel,
		output freq_hz, limit_sel, duty, out_en, dir,
		input  done_ok, done_err, code, code_valid
	);
endinterface

// ==== design/prc_pulse_gen.sv ====
// one pulse output: phase accumulator at the commanded rate and duty
// assumes freq and thr stay steady while run is high
`timescale 1ns/100ps
`include "prc_consts.svh"
module prc_pulse_gen #(
	parameter int AW = 28
) (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// control
	input  wire logic          run,
	input  wire logic [17:0]   freq_hz,
	input  wire logic [AW-1:0] thr,
	// pin
	output logic               pulse
);
	logic [AW-1:0] acc_q;
	logic [AW-1:0] acc_d;
	logic [AW-1:0] sum;
	logic          pulse_q;

	// one full phase turn equals one second of clock, so no divider needed
	assign sum   = acc_q + AW'(freq_hz);
	assign acc_d = !run ? '0 : (sum >= AW'(`PRC_CLK_HZ)) ?
		sum - AW'(`PRC_CLK_HZ) : sum;
	assign pulse = pulse_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q   <= '0;
			pulse_q <= 1'b0;
		end else begin
			acc_q   <= acc_d;
			pulse_q <= run && (acc_q < thr);
		end
	end
endmodule

// ==== design/prc_device.sv ====
// pulse output module end: command interpreter, limit inputs, four outputs
// assumes host drives the link on the same pclk; limit pins are async
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "prc_consts.svh"
module prc_device #(
	parameter logic [7:0] MODULE_ID = 8'h01, // arbitrary neutral value
	parameter bit         ENHANCED  = 1'b1,
	parameter int         NOUT      = 4,
	parameter int         AW        = 28
) (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// command link
	prc_link_if.dev         lk,
	// limit input pins and their limit configuration
	input  wire logic       first_channel_input_c,
	input  wire logic       first_channel_input_d,
	input  wire logic       second_channel_input_c,
	input  wire logic       second_channel_input_d,
	input  wire logic [3:0] limit_cfg,
	// remote link health
	input  wire logic       remote_io_link_up,
	// pulse pins
	output logic [NOUT-1:0] pulse_out,
	output logic [NOUT-1:0] dir_out
);
	localparam logic [3:0] LOAD_CYC = 4'(`PRC_LOAD_CYC);

	prc_pkg::prc_dev_state_t state_q;
	prc_pkg::prc_dev_state_t state_d;

	logic [3:0]      pin_s1_q;
	logic [3:0]      pin_s2_q;
	logic [3:0]      pin_p_q;
	logic [3:0]      cfg_s1_q;
	logic [3:0]      cfg_s2_q;
	logic            link_s1_q;
	logic            link_s2_q;
	logic [3:0]      rise;
	logic [3:0]      fall;
	logic            rtl_p_q;
	logic            rde_p_q;
	logic            rtl_edge;
	logic            rde_edge;
	logic [1:0]      c_out_q;
	logic [7:0]      c_mod_q;
	logic [17:0]     c_freq_q;
	logic [7:0]      c_lim_q;
	logic [7:0]      c_duty_q;
	logic [3:0]      cnt_q;
	logic [15:0]     code_q;
	logic [15:0]     chk_code;
	logic [15:0]     rd_val_q;
	logic            rd_vld_q;
	logic [NOUT-1:0] ok_q;
	logic [NOUT-1:0] err_q;
	logic [NOUT-1:0] armed_q;
	logic [NOUT-1:0] stop;
	logic [17:0]     o_freq_q [NOUT];
	logic [AW-1:0]   o_thr_q  [NOUT];
	logic [7:0]      o_lim_q  [NOUT];
	logic [17:0]     fmax;
	logic [7:0]      duty_eff;
	logic            st_idle;
	logic            st_check;
	logic            st_load;
	logic            st_rderr;
	logic            load_done;
	logic            reachable;

	// selected edge of the selected limit input
	function automatic logic lim_hit(input logic [7:0] sel,
		input logic [3:0] r, input logic [3:0] f);
		logic [1:0] i;
		i = sel[1:0];
		case (sel[`PRC_LIM_EDGE])
		`PRC_EDGE_RISE: lim_hit = r[i];
		`PRC_EDGE_FALL: lim_hit = f[i];
		`PRC_EDGE_BOTH: lim_hit = r[i] | f[i];
		default:        lim_hit = 1'b0;
		endcase
	endfunction

	assign st_idle   = (state_q == prc_pkg::PRC_IDLE);
	assign st_check  = (state_q == prc_pkg::PRC_CHECK);
	assign st_load   = (state_q == prc_pkg::PRC_LOAD);
	assign st_rderr  = (state_q == prc_pkg::PRC_RDERR);
	assign load_done = (cnt_q == 4'h0);
	assign reachable = link_s2_q && (c_mod_q == MODULE_ID);
	assign rise      = pin_s2_q & ~pin_p_q;
	assign fall      = ~pin_s2_q & pin_p_q;
	assign rtl_edge  = lk.run_to_limit_command & ~rtl_p_q;
	assign rde_edge  = lk.read_error_command & ~rde_p_q;
	assign fmax      = ENHANCED ? `PRC_FREQ_MAX_ENH : `PRC_FREQ_MAX_BASE;
	assign duty_eff  = (c_duty_q == 8'h00) ? `PRC_DUTY_HALF : c_duty_q;

	// first failing check wins; order follows what a user fixes first
	assign chk_code =
		!reachable ? `PRC_ERR_NO_LINK :
		(c_lim_q[`PRC_LIM_EDGE] > `PRC_EDGE_BOTH) ? `PRC_ERR_EDGE :
		(c_lim_q[`PRC_LIM_IN] > `PRC_IN_MAX) ? `PRC_ERR_IN_NUM :
		!cfg_s2_q[c_lim_q[1:0]] ? `PRC_ERR_NOT_LIMIT :
		(c_freq_q < `PRC_FREQ_MIN || c_freq_q > fmax) ? `PRC_ERR_CMD :
		(c_duty_q > `PRC_DUTY_MAX) ? `PRC_ERR_CMD :
		`PRC_ERR_NONE;

	always_comb begin
		state_d = state_q;
		case (state_q)
		prc_pkg::PRC_IDLE: begin
			if (rtl_edge)
				state_d = prc_pkg::PRC_CHECK;
			else if (rde_edge)
				state_d = prc_pkg::PRC_RDERR;
		end
		prc_pkg::PRC_CHECK: begin
			if (chk_code == `PRC_ERR_NONE)
				state_d = prc_pkg::PRC_LOAD;
			else
				state_d = prc_pkg::PRC_IDLE;
		end
		prc_pkg::PRC_LOAD: begin
			if (load_done)
				state_d = prc_pkg::PRC_IDLE;
		end
		prc_pkg::PRC_RDERR: state_d = prc_pkg::PRC_IDLE;
		default: state_d = prc_pkg::PRC_IDLE;
		endcase
	end

	// pins and link health are async: two flops before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q  <= 4'h0;
			pin_s2_q  <= 4'h0;
			pin_p_q   <= 4'h0;
			cfg_s1_q  <= 4'h0;
			cfg_s2_q  <= 4'h0;
			link_s1_q <= 1'b0;
			link_s2_q <= 1'b0;
			rtl_p_q   <= 1'b0;
			rde_p_q   <= 1'b0;
		end else begin
			pin_s1_q  <= {second_channel_input_d, second_channel_input_c,
				first_channel_input_d, first_channel_input_c};
			pin_s2_q  <= pin_s1_q;
			pin_p_q   <= pin_s2_q;
			cfg_s1_q  <= limit_cfg;
			cfg_s2_q  <= cfg_s1_q;
			link_s1_q <= remote_io_link_up;
			link_s2_q <= link_s1_q;
			rtl_p_q   <= lk.run_to_limit_command;
			rde_p_q   <= lk.read_error_command;
		end
	end

	// command sequencing; edges seen while busy are dropped on purpose
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= prc_pkg::PRC_IDLE;
			c_out_q  <= 2'h0;
			c_mod_q  <= 8'h00;
			c_freq_q <= 18'h00000;
			c_lim_q  <= 8'h00;
			c_duty_q <= 8'h00;
			cnt_q    <= 4'h0;
			code_q   <= `PRC_ERR_NONE;
			rd_val_q <= `PRC_ERR_NONE;
			rd_vld_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			rd_vld_q <= 1'b0;
			if (st_idle && rtl_edge) begin
				c_out_q  <= lk.out_sel;
				c_mod_q  <= lk.mod_id;
				c_freq_q <= lk.freq_hz;
				c_lim_q  <= lk.limit_sel;
				c_duty_q <= lk.duty;
			end else if (st_idle && rde_edge) begin
				c_mod_q <= lk.mod_id;
			end
			if (st_check) begin
				code_q <= chk_code;
				cnt_q  <= LOAD_CYC - 4'h1;
			end
			if (st_load && !load_done)
				cnt_q <= cnt_q - 4'h1;
			if (st_rderr) begin
				rd_val_q <= reachable ? code_q : `PRC_ERR_NO_LINK;
				rd_vld_q <= 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NOUT; g++) begin : g_out
			logic sel;
			assign sel     = (c_out_q == 2'(g));
			assign stop[g] = lim_hit(o_lim_q[g], rise, fall);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ok_q[g]     <= 1'b0;
					err_q[g]    <= 1'b0;
					armed_q[g]  <= 1'b0;
					o_freq_q[g] <= 18'h00000;
					o_thr_q[g]  <= '0;
					o_lim_q[g]  <= 8'h00;
				end else if (st_idle && rtl_edge && lk.out_sel == 2'(g)) begin
					ok_q[g]    <= 1'b0;
					err_q[g]   <= 1'b0;
					armed_q[g] <= 1'b0;
				end else if (sel && st_check && chk_code != `PRC_ERR_NONE) begin
					err_q[g] <= 1'b1;
				end else if (sel && st_load && load_done) begin
					ok_q[g]     <= 1'b1;
					armed_q[g]  <= 1'b1;
					o_freq_q[g] <= c_freq_q;
					o_thr_q[g]  <= AW'(duty_eff) * AW'(`PRC_DUTY_STEP);
					o_lim_q[g]  <= c_lim_q;
				end else if (armed_q[g] && lk.out_en[g] && stop[g]) begin
					armed_q[g] <= 1'b0;
				end
			end

			prc_pulse_gen #(.AW(AW)) u_gen (
				.pclk    (pclk),
				.presetn (presetn),
				.run     (armed_q[g] & lk.out_en[g]),
				.freq_hz (o_freq_q[g]),
				.thr     (o_thr_q[g]),
				.pulse   (pulse_out[g])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dir_out <= '0;
		else
			dir_out <= lk.dir;
	end

	assign lk.done_ok    = ok_q;
	assign lk.done_err   = err_q;
	assign lk.code       = rd_val_q;
	assign lk.code_valid = rd_vld_q;
endmodule

// ==== design/prc_host.sv ====
// host controller end: apb registers drive the command link
// assumes the module end shares pclk; apb master per amba rules
`timescale 1ns/100ps
`include "prc_consts.svh"
module prc_host (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// interrupt
	output logic             irq,
	// command link
	prc_link_if.host         lk
);
	logic [31:0] prdata_q;
	logic [17:0] freq_q;
	logic [23:0] par_q;
	logic [7:0]  oc_q;
	logic [1:0]  out_q;
	logic        rtl_q;
	logic        rde_q;
	logic        need_rd_q;
	logic        rd_wait_q;
	logic [15:0] code_q;
	logic [2:0]  ist_q;
	logic [2:0]  imask_q;
	logic [3:0]  ok_p_q;
	logic [3:0]  err_p_q;
	logic        wr;
	logic        mapped;
	logic        new_ok;
	logic        new_err;
	logic        blocked;
	logic [2:0]  ev;
	logic [31:0] rsel;

	assign wr      = psel && penable && pwrite;
	assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= `PRC_REG_INT_MASK);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_q;
	assign new_ok  = |(lk.done_ok & ~ok_p_q);
	assign new_err = |(lk.done_err & ~err_p_q);
	assign blocked = need_rd_q || rd_wait_q;
	assign ev      = {lk.code_valid, new_err, new_ok};
	assign irq     = |(ist_q & imask_q);
	assign rsel    =
		(paddr == `PRC_REG_FREQ)     ? {14'h0000, freq_q} :
		(paddr == `PRC_REG_PARAM)    ? {8'h00, par_q} :
		(paddr == `PRC_REG_OUTCTL)   ? {24'h000000, oc_q} :
		(paddr == `PRC_REG_STATUS)   ? {23'h000000, blocked,
			lk.done_err, lk.done_ok} :
		(paddr == `PRC_REG_CODE)     ? {16'h0000, code_q} :
		(paddr == `PRC_REG_INT_STAT) ? {29'h00000000, ist_q} :
		(paddr == `PRC_REG_INT_MASK) ? {29'h00000000, imask_q} :
		{26'h0000000, out_q, 4'h0};

	assign lk.run_to_limit_command = rtl_q;
	assign lk.read_error_command   = rde_q;
	assign lk.mod_id               = par_q[`PRC_PAR_MOD];
	assign lk.out_sel              = out_q;
	assign lk.freq_hz              = freq_q;
	assign lk.limit_sel            = par_q[`PRC_PAR_LIM];
	assign lk.duty                 = par_q[`PRC_PAR_DUTY];
	assign lk.out_en               = oc_q[`PRC_OC_EN];
	assign lk.dir                  = oc_q[`PRC_OC_DIR];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			freq_q   <= 18'h00000;
			par_q    <= 24'h000000;
			oc_q     <= 8'h00;
			out_q    <= 2'h0;
			imask_q  <= 3'h0;
		end else begin
			// latch read data in setup so it stands for the access cycle
			if (psel && !penable)
				prdata_q <= mapped ? rsel : 32'h00000000;
			if (wr && paddr == `PRC_REG_FREQ)
				freq_q <= pwdata[17:0];
			if (wr && paddr == `PRC_REG_PARAM)
				par_q <= pwdata[23:0];
			if (wr && paddr == `PRC_REG_OUTCTL)
				oc_q <= pwdata[7:0];
			if (wr && paddr == `PRC_REG_CTRL)
				out_q <= pwdata[`PRC_CTRL_OUT];
			if (wr && paddr == `PRC_REG_INT_MASK)
				imask_q <= pwdata[2:0];
		end
	end

	// requests are one-cycle pulses, giving the module a clean rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtl_q     <= 1'b0;
			rde_q     <= 1'b0;
			need_rd_q <= 1'b0;
			rd_wait_q <= 1'b0;
			code_q    <= `PRC_ERR_NONE;
			ist_q     <= 3'h0;
			ok_p_q    <= 4'h0;
			err_p_q   <= 4'h0;
		end else begin
			ok_p_q  <= lk.done_ok;
			err_p_q <= lk.done_err;
			rtl_q   <= wr && paddr == `PRC_REG_CTRL &&
				pwdata[`PRC_CTRL_RUN] && !blocked && !new_err;
			rde_q   <= (need_rd_q && !rd_wait_q) ||
				(wr && paddr == `PRC_REG_CTRL && pwdata[`PRC_CTRL_RDE] &&
				!rd_wait_q);
			if (new_err)
				need_rd_q <= 1'b1;
			else if (need_rd_q && !rd_wait_q)
				need_rd_q <= 1'b0;
			if (rde_q)
				rd_wait_q <= 1'b1;
			else if (lk.code_valid)
				rd_wait_q <= 1'b0;
			if (lk.code_valid)
				code_q <= lk.code;
			// a new event wins over a write-one-to-clear in the same cycle
			if (wr && paddr == `PRC_REG_INT_STAT)
				ist_q <= (ist_q & ~pwdata[2:0]) | ev;
			else
				ist_q <= ist_q | ev;
		end
	end
endmodule

// ==== dv/prc_link_sva.sv ====
// checker for the command link: done flags, error codes, command pulses
// assumes both ends share pclk; fed the link interface signals by name
`timescale 1ns/100ps
`include "prc_consts.svh"
module prc_link_sva (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// link signals
	input wire logic        run_to_limit_command,
	input wire logic        read_error_command,
	input wire logic [3:0]  done_ok,
	input wire logic [3:0]  done_err,
	input wire logic [15:0] code,
	input wire logic        code_valid
);
	logic [3:0] quiet_q;
	logic [3:0] quiet_d;
	// saturating count since the last run pulse; flags may move before 15
	assign quiet_d = run_to_limit_command ? 4'h0 :
		(quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			quiet_q <= 4'h0;
		else
			quiet_q <= quiet_d;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_done_exclusive: assert property (
		(done_ok & done_err) == 4'h0) else $error("ok and error both set");
	a_err_latency: assert property (
		(done_err & ~$past(done_err)) != 4'h0 |->
		$past(run_to_limit_command, 2) || $past(run_to_limit_command, 3))
		else $error("error flag without run two cycles before");
	a_ok_latency: assert property (
		(done_ok & ~$past(done_ok)) != 4'h0 |->
		$past(run_to_limit_command, 10) || $past(run_to_limit_command, 11))
		else $error("ok flag not ten cycles after run");
	a_done_hold: assert property (
		quiet_q == 4'hF |-> $stable(done_ok) && $stable(done_err))
		else $error("done flags moved without a command");
	a_code_hold: assert property (!code_valid |-> $stable(code))
		else $error("code moved without valid");
	a_code_legal: assert property (
		code_valid |-> code inside {`PRC_ERR_NONE,
		[`PRC_ERR_CMD:`PRC_ERR_REG_CFG], `PRC_ERR_NO_LINK})
		else $error("code outside the defined set");
	a_code_answer: assert property (
		$rose(code_valid) |->
		$past(read_error_command, 2) || $past(read_error_command, 3))
		else $error("code valid without read request");
	a_valid_pulse: assert property (code_valid |=> !code_valid)
		else $error("code valid longer than one cycle");
	a_auto_read: assert property (
		(done_err & ~$past(done_err)) != 4'h0 |-> ##[0:3] read_error_command)
		else $error("no read request after error");
	a_run_pulse: assert property (
		run_to_limit_command |=> !run_to_limit_command)
		else $error("run request longer than one cycle");
endmodule

// ==== dv/tb_top.sv ====
// bench: apb host end joined to the module end over the command link
// assumes 200 MHz pclk; limit pins and link health driven here
`timescale 1ns/100ps
`include "prc_consts.svh"
module tb_top;
	localparam int NC = 8;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        in_c1 = 1'b0;
	logic        in_d1 = 1'b0;
	logic        in_c2 = 1'b0;
	logic        in_d2 = 1'b0;
	logic [3:0]  limit_cfg = 4'hF;
	logic        link_up = 1'b1;
	logic [3:0]  pulse_out;
	logic [3:0]  dir_out;
	logic        serr;
	logic [31:0] st;
	int          error_cnt = 0;
	int          check_count = 0;
	int          hi;
	// one failing case per row, in the device's check order except the two no-link rows, which come last
	logic [7:0]  c_lim[NC] = '{8'h30, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};
	logic [7:0]  c_dut[NC] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h64,
		8'h00, 8'h00};
	logic [17:0] c_frq[NC] = '{18'h003E8, 18'h003E8, 18'h003E8, 18'h00013,
		18'h3D091, 18'h003E8, 18'h003E8, 18'h003E8};
	logic [3:0]  c_cfg[NC] = '{4'hF, 4'hF, 4'hD, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
	logic        c_up[NC] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	logic [7:0]  c_mod[NC] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
		8'h01, 8'h02};
	logic [15:0] c_code[NC] = '{`PRC_ERR_EDGE, `PRC_ERR_IN_NUM,
		`PRC_ERR_NOT_LIMIT, `PRC_ERR_CMD, `PRC_ERR_CMD, `PRC_ERR_CMD,
		`PRC_ERR_NO_LINK, `PRC_ERR_NO_LINK};
	prc_link_if lk ();
	always #2.5 pclk = ~pclk;
	prc_host i_prc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.lk(lk.host));
	prc_device i_prc_device (.pclk(pclk), .presetn(presetn), .lk(lk.dev),
		.first_channel_input_c(in_c1), .first_channel_input_d(in_d1),
		.second_channel_input_c(in_c2), .second_channel_input_d(in_d2),
		.limit_cfg(limit_cfg), .remote_io_link_up(link_up),
		.pulse_out(pulse_out), .dir_out(dir_out));
	prc_link_sva i_prc_link_sva (.pclk(pclk), .presetn(presetn),
		.run_to_limit_command(lk.run_to_limit_command),
		.read_error_command(lk.read_error_command), .done_ok(lk.done_ok),
		.done_err(lk.done_err), .code(lk.code), .code_valid(lk.code_valid));
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			complete_run();
		end
		st = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// polls the interrupt status until a bit of m is set
	task automatic poll(input logic [31:0] m);
		int n;
		n = 0;
		do begin
			xfer(1'b0, `PRC_REG_INT_STAT, 32'h0);
			n++;
		end while ((st & m) == 32'h0 && n < 40);
		if (n >= 40) begin
			error_cnt++;
			complete_run();
		end
	endtask
	task automatic cmd(input logic [31:0] ctl, input logic [31:0] m);
		xfer(1'b1, `PRC_REG_INT_STAT, 32'h7);
		xfer(1'b1, `PRC_REG_CTRL, ctl);
		poll(m);
		check("irq", {31'h0, irq}, 32'h1);
		xfer(1'b0, `PRC_REG_STATUS, 32'h0);
	endtask
	task automatic setp(input logic [17:0] f, input logic [23:0] p);
		xfer(1'b1, `PRC_REG_FREQ, {14'h0, f});
		xfer(1'b1, `PRC_REG_PARAM, {8'h00, p});
	endtask
	task automatic count_hi();
		hi = 0;
		repeat (1600) begin
			@(posedge pclk);
			if (pulse_out[0] === 1'b1)
				hi++;
		end
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b1, `PRC_REG_INT_MASK, 32'h7);
		xfer(1'b0, 8'h20, 32'h0);
		check("unmapped_err", {31'h0, serr}, 32'h1);
		check("unmapped_data", st, 32'h0);
		for (int i = 0; i < NC; i++) begin
			limit_cfg <= c_cfg[i];
			link_up <= c_up[i];
			setp(c_frq[i], {c_mod[i], c_dut[i], c_lim[i]});
			cmd(32'h11, 32'h5);
			check("status_err", st & 32'h22, 32'h20);
			xfer(1'b0, `PRC_REG_CODE, 32'h0);
			check("code", st, {16'h0, c_code[i]});
		end
		limit_cfg <= 4'hF;
		link_up <= 1'b1;
		setp(18'h00014, {8'h01, 8'h63, 8'h23});
		cmd(32'h31, 32'h5);
		check("status_ok3", st & 32'h88, 32'h08);
		cmd(32'h02, 32'h4);
		xfer(1'b0, `PRC_REG_CODE, 32'h0);
		check("code_replaced", st, 32'h0);
		setp(18'h3D090, {8'h01, 8'h00, 8'h00});
		cmd(32'h01, 32'h5);
		check("status_ok0", st & 32'h11, 32'h01);
		xfer(1'b1, `PRC_REG_OUTCTL, 32'h11);
		repeat (2) @(posedge pclk);
		check("dir", {28'h0, dir_out}, 32'h1);
		count_hi();
		check("duty_half", {31'h0, hi >= 796 && hi <= 804}, 32'h1);
		in_c1 <= 1'b1;
		repeat (10) @(posedge pclk);
		count_hi();
		check("stopped", hi, 32'h0);
		// rearm output 0 on the falling edge of the same pin
		setp(18'h3D090, {8'h01, 8'h00, 8'h10});
		cmd(32'h01, 32'h5);
		count_hi();
		check("rerun", {31'h0, hi >= 796 && hi <= 804}, 32'h1);
		in_c1 <= 1'b0;
		repeat (10) @(posedge pclk);
		count_hi();
		check("stopped_fall", hi, 32'h0);
		xfer(1'b1, `PRC_REG_INT_MASK, 32'h0);
		// the mask register only takes the write at the access edge
		@(posedge pclk);
		check("irq_masked", {31'h0, irq}, 32'h0);
		xfer(1'b1, `PRC_REG_INT_MASK, 32'h7);
		xfer(1'b1, `PRC_REG_INT_STAT, 32'h7);
		@(posedge pclk);
		check("irq_cleared", {31'h0, irq}, 32'h0);
		// second request lands while the first output is still loading
		xfer(1'b1, `PRC_REG_CTRL, 32'h11);
		xfer(1'b1, `PRC_REG_CTRL, 32'h21);
		poll(32'h1);
		xfer(1'b0, `PRC_REG_STATUS, 32'h0);
		check("refused", st & 32'h66, 32'h02);
		complete_run();
	end
endmodule
